// file: logic/btbs_defs.vh
// Constants shared by the branch target cache sequencer design.
`ifndef BTBS_DEFS_VH
`define BTBS_DEFS_VH
// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define BTBS_ENTRIES 32
`define BTBS_WAYS 4
`define BTBS_SETS 8
`define BTBS_SET_W 3
`define BTBS_ADDR_W 32
`define BTBS_TAG_W 27
`define BTBS_TAG_LSB 5
`define BTBS_SET_LSB 2
`define BTBS_SET_MSB 4
`define BTBS_LRU_W 8
`define BTBS_LRU_RST 8'he4
// ----------------------------------------------------------------------
// Prediction options carried by a branch
// ----------------------------------------------------------------------
`define BTBS_OPT_NONE 2'h0
`define BTBS_OPT_PREDICT 2'h1
`define BTBS_OPT_NO_PREDICT 2'h2
// ----------------------------------------------------------------------
// Pipeline
// ----------------------------------------------------------------------
`define BTBS_DEPTH_SHORT 8
`define BTBS_DEPTH_LONG 10
`define BTBS_DEPTH_MAX 10
`define BTBS_WORD_STEP 32'h0000_0004
`define BTBS_RESET_PC 32'h0000_0000
`endif

// file: logic/btbs_way_select.v
// LRU age tracking and victim choice for one set of the branch target cache.
`timescale 1ns/10ps
`default_nettype none
`include "btbs_defs.vh"

module btbs_way_select (
  input wire [`BTBS_LRU_W-1:0] ages_i,
  input wire [1:0] touch_way_i,
  output reg [`BTBS_LRU_W-1:0] ages_o,
  output reg [1:0] victim_o
);

  // ----------------------------------------------------------------------
  // Age update
  // ----------------------------------------------------------------------
  // Each way holds a two-bit age; 3 is most recent. The touched way becomes 3
  // and every way younger than its old age moves down one, so ages stay unique.
  integer k;
  reg [1:0] old_age;
  reg [1:0] a;
  always @* begin
    old_age = ages_i[touch_way_i*2 +: 2];
    ages_o = ages_i;
    victim_o = 2'h0;
    for (k = 0; k < `BTBS_WAYS; k = k + 1) begin
      a = ages_i[k*2 +: 2];
      if (a == 2'h0) begin
        victim_o = k[1:0]; // R9
      end
      if (k[1:0] == touch_way_i) begin
        ages_o[k*2 +: 2] = 2'h3; // R9
      end else if (a > old_age) begin
        ages_o[k*2 +: 2] = a - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/btbs_sequencer.v
// Program sequencer fetch steering with a 4-way branch target cache.
`timescale 1ns/10ps
`default_nettype none
`include "btbs_defs.vh"

// Operation
// R1 - Branch target cache holds 32 entries as 8 sets of four ways.
// R2 - Record resolved branch targets so later fetches redirect early.
// R3 - Lookup and update happen only when enabled and the branch is predicted.
// R4 - No option means predicted; explicit options force predicted or not.
// R5 - Not-predicted branches never change cache contents, taken or not.
// R6 - Fully interlocked pipeline of 8 or 10 stages, stalling on hazards.
// R7 - Sequential fetch costs nothing; only non-sequential flow disrupts fetch.
// R8 - No instruction cache; one fetch and two data accesses share a cycle.
// R9 - LRU victim on allocation; flush and refetch on a mispredicted target.
module btbs_sequencer #(
  parameter LONG_PIPE = 0
) (
  input wire clk_i,
  input wire resetn_i,
  input wire cache_enable_i,
  input wire hazard_i,
  input wire fetch_ready_i,
  input wire [`BTBS_ADDR_W-1:0] fetch_pc_i,
  input wire fetch_is_branch_i,
  input wire [1:0] fetch_option_i,
  input wire resolve_valid_i,
  input wire [`BTBS_ADDR_W-1:0] resolve_pc_i,
  input wire [1:0] resolve_option_i,
  input wire resolve_taken_i,
  input wire [`BTBS_ADDR_W-1:0] resolve_target_i,
  input wire resolve_was_redirected_i,
  input wire [`BTBS_ADDR_W-1:0] resolve_pred_target_i,
  input wire nonseq_valid_i,
  input wire [`BTBS_ADDR_W-1:0] nonseq_target_i,
  output reg [`BTBS_ADDR_W-1:0] next_fetch_pc_o,
  output reg fetch_valid_o,
  output reg flush_o,
  output reg stall_o,
  output reg early_redirect_o,
  output reg [`BTBS_ADDR_W-1:0] pred_target_o,
  output reg data_port_a_en_o,
  output reg data_port_b_en_o,
  output wire [3:0] pipe_depth_o
);

  // ----------------------------------------------------------------------
  // Cache storage
  // ----------------------------------------------------------------------
  // Arrays are flat: entry index is set*4+way. Size comes from 32 entries.
  reg [`BTBS_TAG_W-1:0] tag_r [0:`BTBS_ENTRIES-1]; // R1
  reg [`BTBS_ADDR_W-1:0] tgt_r [0:`BTBS_ENTRIES-1];
  reg [`BTBS_ENTRIES-1:0] vld_r;
  reg [`BTBS_LRU_W-1:0] lru_r [0:`BTBS_SETS-1];
  reg [`BTBS_DEPTH_MAX-1:0] pipe_r;
  reg [`BTBS_ADDR_W-1:0] pc_r;

  // Depth constants are held at the port's width so the select does not truncate.
  localparam [3:0] DEPTH_SHORT = `BTBS_DEPTH_SHORT;
  localparam [3:0] DEPTH_LONG = `BTBS_DEPTH_LONG;
  assign pipe_depth_o = LONG_PIPE ? DEPTH_LONG : DEPTH_SHORT; // R6

  // Absent option means predicted; only an explicit no-predict disables it.
  wire fetch_pred = (fetch_option_i != `BTBS_OPT_NO_PREDICT); // R4
  wire res_pred = (resolve_option_i != `BTBS_OPT_NO_PREDICT); // R4

  wire [`BTBS_SET_W-1:0] f_set = fetch_pc_i[`BTBS_SET_MSB:`BTBS_SET_LSB];
  wire [`BTBS_TAG_W-1:0] f_tag = fetch_pc_i[`BTBS_ADDR_W-1:`BTBS_TAG_LSB];
  wire [`BTBS_SET_W-1:0] r_set = resolve_pc_i[`BTBS_SET_MSB:`BTBS_SET_LSB];
  wire [`BTBS_TAG_W-1:0] r_tag = resolve_pc_i[`BTBS_ADDR_W-1:`BTBS_TAG_LSB];

  // ----------------------------------------------------------------------
  // Parallel way compare
  // ----------------------------------------------------------------------
  wire [`BTBS_WAYS-1:0] f_hit;
  wire [`BTBS_WAYS-1:0] r_hit;
  genvar g;
  generate
    for (g = 0; g < `BTBS_WAYS; g = g + 1) begin : g_way
      // A sized copy of the way number, since a genvar cannot be part-selected.
      localparam [1:0] WAY = g;
      assign f_hit[g] = vld_r[{f_set, WAY}] && (tag_r[{f_set, WAY}] == f_tag);
      assign r_hit[g] = vld_r[{r_set, WAY}] && (tag_r[{r_set, WAY}] == r_tag);
    end
  endgenerate

  reg [1:0] f_way;
  reg [1:0] r_way;
  integer i;
  always @* begin
    f_way = 2'h0;
    r_way = 2'h0;
    for (i = 0; i < `BTBS_WAYS; i = i + 1) begin
      if (f_hit[i]) begin
        f_way = i[1:0];
      end
      if (r_hit[i]) begin
        r_way = i[1:0];
      end
    end
  end

  // Consult only for an enabled cache and a predicted branch.
  wire lookup_hit = cache_enable_i && fetch_is_branch_i && fetch_pred && (|f_hit); // R3

  // ----------------------------------------------------------------------
  // Update decision
  // ----------------------------------------------------------------------
  // A not-predicted branch writes nothing, so loop code marked that way keeps
  // its entries; the cost is no early redirect for that branch.
  wire upd = resolve_valid_i && cache_enable_i && res_pred; // R3 R5
  wire r_any = |r_hit;
  wire mispredict = resolve_valid_i &&
    ((resolve_taken_i && (!resolve_was_redirected_i ||
      (resolve_pred_target_i != resolve_target_i))) ||
     (!resolve_taken_i && resolve_was_redirected_i)); // R9

  wire [1:0] victim;
  wire [`BTBS_LRU_W-1:0] r_ages_nxt;
  wire [1:0] touch = r_any ? r_way : victim;
  btbs_way_select u_way_select (
    .ages_i(lru_r[r_set]),
    .touch_way_i(touch),
    .ages_o(r_ages_nxt),
    .victim_o(victim)
  );

  // ----------------------------------------------------------------------
  // Cache write
  // ----------------------------------------------------------------------
  // Taken branches allocate or refresh; a hit that fell through is dropped so
  // the next pass does not redirect wrongly.
  integer j;
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      vld_r <= {`BTBS_ENTRIES{1'b0}};
      for (j = 0; j < `BTBS_SETS; j = j + 1) begin
        lru_r[j] <= `BTBS_LRU_RST;
      end
    end else if (upd) begin // R5
      if (resolve_taken_i) begin
        tag_r[{r_set, touch}] <= r_tag; // R2
        tgt_r[{r_set, touch}] <= resolve_target_i; // R2
        vld_r[{r_set, touch}] <= 1'b1;
        lru_r[r_set] <= r_ages_nxt; // R9
      end else if (r_any) begin
        vld_r[{r_set, r_way}] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fetch steering
  // ----------------------------------------------------------------------
  // Priority: mispredict flush, then other non-sequential flow, then early
  // redirect, then the plain next word, which never inserts a bubble.
  always @* begin
    next_fetch_pc_o = pc_r + `BTBS_WORD_STEP; // R7
    flush_o = 1'b0;
    early_redirect_o = 1'b0;
    pred_target_o = tgt_r[{f_set, f_way}];
    if (mispredict) begin
      flush_o = 1'b1; // R9
      next_fetch_pc_o = resolve_taken_i ? resolve_target_i
                                        : resolve_pc_i + `BTBS_WORD_STEP;
    end else if (nonseq_valid_i) begin
      flush_o = 1'b1; // R7
      next_fetch_pc_o = nonseq_target_i;
    end else if (lookup_hit) begin
      early_redirect_o = 1'b1; // R2
      next_fetch_pc_o = tgt_r[{f_set, f_way}];
    end
  end

  // ----------------------------------------------------------------------
  // Interlock and pipeline occupancy
  // ----------------------------------------------------------------------
  // Hazards or a busy fetch port freeze the PC instead of needing software
  // delay slots, though a flush still loads it. Fetch and both data ports run together with no cache,
  // except that a flush during a stall makes fetch valid while both data ports stay off.
  always @* begin
    stall_o = hazard_i || !fetch_ready_i; // R6
    fetch_valid_o = !stall_o || flush_o; // R8
    data_port_a_en_o = !stall_o; // R8
    data_port_b_en_o = !stall_o; // R8
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pc_r <= `BTBS_RESET_PC;
      pipe_r <= {`BTBS_DEPTH_MAX{1'b0}};
    end else if (flush_o) begin
      pc_r <= next_fetch_pc_o; // R9
      pipe_r <= {`BTBS_DEPTH_MAX{1'b0}};
    end else if (!stall_o) begin
      pc_r <= next_fetch_pc_o;
      pipe_r <= {pipe_r[`BTBS_DEPTH_MAX-2:0], 1'b1}; // R6
    end
  end

endmodule
`default_nettype wire

// file: testbench/btbs_seq_checker.sv
// Port-level assertion checker for the branch target cache sequencer.
`timescale 1ns/10ps
`default_nettype none
module btbs_seq_checker #(parameter LONG_PIPE = 0) (
  input wire clk_i,
  input wire resetn_i,
  input wire cache_enable_i,
  input wire hazard_i,
  input wire [1:0] fetch_option_i,
  input wire resolve_valid_i,
  input wire [31:0] resolve_pc_i,
  input wire resolve_taken_i,
  input wire [31:0] resolve_target_i,
  input wire resolve_was_redirected_i,
  input wire nonseq_valid_i,
  input wire [31:0] nonseq_target_i,
  input wire [31:0] next_fetch_pc_o,
  input wire flush_o,
  input wire stall_o,
  input wire early_redirect_o,
  input wire data_port_a_en_o,
  input wire data_port_b_en_o,
  input wire [3:0] pipe_depth_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_depth_fixed: assert property (pipe_depth_o == (LONG_PIPE ? 4'ha : 4'h8))
    else $error("pipe depth wrong");
  chk_ports_open: assert property (data_port_a_en_o == !stall_o && data_port_b_en_o == !stall_o)
    else $error("data port enables wrong");
  chk_hazard_stall: assert property (hazard_i |-> stall_o)
    else $error("hazard without stall");
  chk_seq_noflush: assert property (!resolve_valid_i && !nonseq_valid_i |-> !flush_o)
    else $error("flush on sequential fetch");
  chk_nonseq_jump: assert property (nonseq_valid_i && !resolve_valid_i |-> flush_o
    && next_fetch_pc_o == nonseq_target_i) else $error("non-sequential redirect wrong");
  chk_np_nolookup: assert property (fetch_option_i == 2'h2 || !cache_enable_i
    |-> !early_redirect_o) else $error("lookup while not predicted");
  chk_miss_flush: assert property (resolve_valid_i && resolve_taken_i && !resolve_was_redirected_i
    |-> flush_o && next_fetch_pc_o == resolve_target_i) else $error("taken miss not flushed");
  chk_nt_refetch: assert property (resolve_valid_i && !resolve_taken_i && resolve_was_redirected_i
    |-> flush_o && next_fetch_pc_o == resolve_pc_i + 32'h4) else $error("refetch address wrong");
endmodule
bind btbs_sequencer btbs_seq_checker #(.LONG_PIPE(LONG_PIPE)) chk_u (.*);
`default_nettype wire

// file: testbench/btbs_fetch_model.sv
// Behavioural fetch unit that fetches whatever address the sequencer names.
`timescale 1ns/10ps
`default_nettype none
module btbs_fetch_model (
  input wire clk_i,
  input wire resetn_i,
  input wire slow_i,
  input wire [31:0] next_pc_i,
  output logic ready_o,
  output logic [31:0] pc_o
);
  logic toggle_r;
  // ----------------------------------------------------------------------
  // Fetch port
  // ----------------------------------------------------------------------
  // A slow port accepts every other cycle, so the sequencer must hold its address.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      toggle_r <= 1'b0;
      pc_o <= 32'h0;
    end else begin
      toggle_r <= ~toggle_r;
      if (ready_o) begin
        pc_o <= next_pc_i;
      end
    end
  end
  assign ready_o = !slow_i || toggle_r;
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking testbench for the branch target cache sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "btbs_defs.vh"
module tb;
  logic clk_i, resetn_i, cache_enable_i, hazard_i, fetch_ready_i, fetch_is_branch_i, slow;
  logic resolve_valid_i, resolve_taken_i, resolve_was_redirected_i, nonseq_valid_i;
  logic [1:0] fetch_option_i, resolve_option_i;
  logic [31:0] fetch_pc_i, resolve_pc_i, resolve_target_i, resolve_pred_target_i;
  logic [31:0] nonseq_target_i, next_fetch_pc_o, pred_target_o;
  logic fetch_valid_o, flush_o, stall_o, early_redirect_o, data_port_a_en_o, data_port_b_en_o;
  logic [3:0] pipe_depth_o;
  int n_fail, comparisons;
  btbs_sequencer #(.LONG_PIPE(0)) dut_u (.*);
  btbs_fetch_model fetch_u (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
    .next_pc_i(next_fetch_pc_o), .ready_o(fetch_ready_i), .pc_o(fetch_pc_i));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One resolve cycle; a wrong guess must flush to the correct address.
  task automatic put(input logic [31:0] pc, input logic [31:0] tgt, input logic [1:0] opt,
                     input logic tk, input logic rd);
    resolve_pc_i = pc;
    resolve_target_i = tgt;
    resolve_pred_target_i = tgt;
    resolve_option_i = opt;
    resolve_taken_i = tk;
    resolve_was_redirected_i = rd;
    resolve_valid_i = 1'b1;
    #2;
    check("flush", {31'h0, tk ^ rd}, {31'h0, flush_o});
    if (tk ^ rd) check("refetch pc", tk ? tgt : pc + 32'h4, next_fetch_pc_o);
    @(posedge clk_i) #1;
    resolve_valid_i = 1'b0;
  endtask
  // Steer fetch to pc with a jump, then present it as a branch.
  task automatic look(input logic [31:0] pc, input logic [31:0] tgt, input logic [1:0] opt,
                      input logic hit);
    nonseq_target_i = pc;
    nonseq_valid_i = 1'b1;
    @(posedge clk_i) #1;
    nonseq_valid_i = 1'b0;
    fetch_is_branch_i = 1'b1;
    fetch_option_i = opt;
    #2;
    check("fetch pc", pc, fetch_pc_i);
    check("early redirect", {31'h0, hit}, {31'h0, early_redirect_o});
    if (hit) check("redirect pc", tgt, next_fetch_pc_o);
    if (hit) check("predicted target", tgt, pred_target_o);
    @(posedge clk_i) #1;
    fetch_is_branch_i = 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_options();
    put(32'h100, 32'h4000, `BTBS_OPT_NONE, 1'b1, 1'b1);
    look(32'h100, 32'h4000, `BTBS_OPT_NONE, 1'b1);
    look(32'h100, 32'h4000, `BTBS_OPT_PREDICT, 1'b1);
    look(32'h100, 32'h4000, 2'h3, 1'b1);
    look(32'h100, 32'h4000, `BTBS_OPT_NO_PREDICT, 1'b0);
    put(32'h100, 32'h4000, `BTBS_OPT_NO_PREDICT, 1'b0, 1'b0);
    look(32'h100, 32'h4000, `BTBS_OPT_NONE, 1'b1);
    put(32'h200, 32'h5000, `BTBS_OPT_NO_PREDICT, 1'b1, 1'b0);
    look(32'h200, 32'h5000, `BTBS_OPT_NONE, 1'b0);
    cache_enable_i = 1'b0;
    put(32'h300, 32'h6000, `BTBS_OPT_NONE, 1'b1, 1'b1);
    look(32'h100, 32'h4000, `BTBS_OPT_NONE, 1'b0);
    cache_enable_i = 1'b1;
    look(32'h300, 32'h6000, `BTBS_OPT_NONE, 1'b0);
  endtask
  // Five tags in one set: the oldest must be the one evicted.
  task automatic t_lru();
    for (int k = 1; k <= 5; k++) put({k[26:0], 5'h0c}, {k[26:0], 5'h10}, 2'h0, 1'b1, 1'b1);
    look(32'h2c, 32'h30, `BTBS_OPT_NONE, 1'b0);
    for (int k = 2; k <= 5; k++) look({k[26:0], 5'h0c}, {k[26:0], 5'h10}, 2'h0, 1'b1);
  endtask
  task automatic t_flush();
    put(32'h400, 32'h800, `BTBS_OPT_NONE, 1'b1, 1'b0);
    put(32'h400, 32'h800, `BTBS_OPT_NONE, 1'b0, 1'b1);
  endtask
  // Hazard stalls everything; a slow fetch port alone must never flush.
  task automatic t_stall();
    check("depth", 32'h8, {28'h0, pipe_depth_o});
    hazard_i = 1'b1;
    #2;
    check("stall", 32'h1, {31'h0, stall_o});
    check("data ports", 32'h0, {30'h0, data_port_a_en_o, data_port_b_en_o});
    check("fetch valid", 32'h0, {31'h0, fetch_valid_o});
    @(posedge clk_i) #1;
    hazard_i = 1'b0;
    slow = 1'b1;
    repeat (4) begin
      @(posedge clk_i) #2;
      check("sequential flush", 32'h0, {31'h0, flush_o});
      check("slow stall", {31'h0, !fetch_ready_i}, {31'h0, stall_o});
      check("data ports", fetch_ready_i ? 32'h3 : 32'h0, {30'h0, data_port_a_en_o, data_port_b_en_o});
    end
    slow = 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  initial begin
    {resetn_i, hazard_i, fetch_is_branch_i, slow, resolve_valid_i, nonseq_valid_i} = 6'h0;
    {resolve_taken_i, resolve_was_redirected_i, fetch_option_i, resolve_option_i} = 6'h0;
    {resolve_pc_i, resolve_target_i, resolve_pred_target_i, nonseq_target_i} = 128'h0;
    cache_enable_i = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_stall();
    t_options();
    t_lru();
    t_flush();
    end_sim();
  end
endmodule
`default_nettype wire
